// [src/modbus_consts.svh]
// constants of the serial-line slave decoder
`ifndef MODBUS_CONSTS_SVH
`define MODBUS_CONSTS_SVH
// operation codes
`define OPC_RD_HOLD 8'h03
`define OPC_RD_INPUT 8'h04
`define OPC_WR_SINGLE 8'h06
`define OPC_DIAG 8'h08
`define OPC_WR_MULTI 8'h10
`define OPC_RDWR_MULTI 8'h17
`define OPC_ENCAP 8'h2B
`define OPC_DICT_ALL 8'h65
`define OPC_DICT_OBJ 8'h66
`define OPC_ERR_BIT 8'h80
// subcodes
`define SUB_CLEAR 8'h0A
`define SUB_FIRST_CNT 8'h0B
`define SUB_LAST_CNT 8'h12
`define SUB_START 8'h55
`define SUB_NEXT 8'hAA
`define MEI_CAN 8'h0D
`define SUB_HI_ZERO 8'h00
// exception codes
`define EXC_ILL_FUNC 8'h01
`define EXC_ILL_ADDR 8'h02
`define EXC_ILL_VALUE 8'h03
`define EXC_NONE 8'h00
// station and frame layout
`define BCAST_ADDR 8'h00
`define REG_COUNT_MAX 16'h007D
`define REQ_FIXED_LEN 8'h08
`define FRAME_MIN_LEN 8'h04
`define RX_CNT_MAX 8'hFF
`define POS_STATION 3'h0
`define POS_OP 3'h1
`define POS_F0 3'h2
`define POS_F1 3'h3
`define POS_F2 3'h4
`define POS_F3 3'h5
`define EXC_BODY_LEN 8'h03
`define ECHO_BODY_LEN 8'h06
`define READ_HDR_LEN 8'h03
// crc
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define CRC_GOOD 16'h0000
`define BYTE_BITS 8
// diagnostic counters
`define NUM_COUNTERS 8
`define CNT_BUS_MSG 3'h0
`define CNT_BUS_ERR 3'h1
`define CNT_BUS_EXC 3'h2
`define CNT_SRV_MSG 3'h3
`define CNT_SRV_NO_RESP 3'h4
`define CNT_SRV_NAK 3'h5
`define CNT_SRV_BUSY 3'h6
`define CNT_OVERRUN 3'h7
`endif

// [src/modbus_pkg.sv]
// shared types of the slave decoder
`default_nettype none
package modbus_pkg;
  typedef enum logic [2:0] {
    st_idle, st_check, st_read, st_write, st_body, st_crc_load, st_crc_lo, st_crc_hi
  } dec_state_e;
  typedef enum logic [1:0] {resp_exc, resp_read, resp_echo} resp_kind_e;
endpackage
`default_nettype wire

// [src/decoder_links.sv]
// links between the decoder and its crc and counter units
`default_nettype none
`include "modbus_consts.svh"
interface crc_link;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport engine (input clr, input en, input data, output crc);
  modport user (output clr, output en, output data, input crc);
endinterface
interface diag_link;
  logic [`NUM_COUNTERS-1:0] inc;
  logic clr;
  logic [2:0] sel;
  logic [15:0] value;
  logic [`NUM_COUNTERS-1:0] flags;
  modport engine (input inc, input clr, input sel, output value, output flags);
  modport user (output inc, output clr, output sel, input value, input flags);
endinterface
`default_nettype wire

// [src/crc16_engine.sv]
// running crc-16 over a byte stream
`default_nettype none
`include "modbus_consts.svh"
module crc16_engine (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // byte stream and remainder
  crc_link.engine lk
);
  typedef struct packed {
    logic [15:0] crc;
  } crc_s;
  crc_s crc_reg;
  crc_s crc_next;

  always_comb begin
    crc_next = crc_reg;
    if (lk.clr) begin
      crc_next.crc = `CRC_INIT;
    end else if (lk.en) begin
      crc_next.crc = crc_reg.crc ^ {8'h00, lk.data};
      for (int b = 0; b < `BYTE_BITS; b++) begin
        crc_next.crc = crc_next.crc[0] ? ((crc_next.crc >> 1) ^ `CRC_POLY) : (crc_next.crc >> 1);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_reg <= '{crc: `CRC_INIT};
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign lk.crc = crc_reg.crc;
endmodule // crc16_engine
`default_nettype wire

// [src/diag_counters.sv]
// communication event counters and sticky saturation flags
`default_nettype none
`include "modbus_consts.svh"
module diag_counters #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // events, clear and readout
  diag_link.engine lk
);
  typedef struct packed {
    logic [`NUM_COUNTERS-1:0][WIDTH-1:0] cnt;
    logic [`NUM_COUNTERS-1:0] flags;
  } diag_s;
  diag_s diag_reg;
  diag_s diag_next;

  // clear first, then count: an event in the clear cycle survives
  always_comb begin
    diag_next = diag_reg;
    for (int i = 0; i < `NUM_COUNTERS; i++) begin
      if (lk.clr) begin
        diag_next.cnt[i] = '0;
        diag_next.flags[i] = 1'b0;
      end
      if (lk.inc[i]) begin
        if (&diag_next.cnt[i]) begin
          diag_next.flags[i] = 1'b1;
        end else begin
          diag_next.cnt[i] = diag_next.cnt[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_reg <= '0;
    end else begin
      diag_reg <= diag_next;
    end
  end

  assign lk.value = 16'(diag_reg.cnt[lk.sel]);
  assign lk.flags = diag_reg.flags;
endmodule // diag_counters
`default_nettype wire

// [src/modbus_rtu_slave_function_decoder.sv]
// request decoder and response builder for the serial-line slave
`default_nettype none
`include "modbus_consts.svh"
// Contract
// - station 0 broadcast executes, never answers
// - recognise 03,04,06,10,17,08 and 2B/0D
// - diag 0A clears counters and diag register
// - diag 0B..12 each return one counter
// - 65h reads dictionary, 55 start, AA next
// - 66h reads array/record, 55 start, AA next
// - read carries start address, count 1..7D
// - read answer: echo, byte count, values
// - process data reads need 4-byte alignment
// - single write carries address, value; echoed
// - failure answer: function plus 80h, code
// - fields most significant byte first
module modbus_rtu_slave_function_decoder
  import modbus_pkg::*;
#(
  parameter int MAX_REGS = int'(`REG_COUNT_MAX),
  parameter logic [15:0] PDO_LO = 16'h0000,
  parameter logic [15:0] PDO_HI = 16'h0FFF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // station identity
  input wire logic [7:0] station_addr,
  // received bytes from the framer
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_overrun,
  // response bytes to the framer
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  // register storage
  output logic reg_req,
  output logic reg_we,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0] reg_exc,
  // long-format functions served elsewhere
  output logic ext_req,
  output logic [7:0] ext_func,
  output logic [7:0] ext_sub,
  // diagnostics
  output logic [`NUM_COUNTERS-1:0] diag_status
);
  typedef struct packed {
    dec_state_e st;
    logic [`REQ_FIXED_LEN-1:0][7:0] req;
    logic [7:0] rx_cnt;
    resp_kind_e kind;
    logic [7:0] exc;
    logic [MAX_REGS-1:0][15:0] words;
    logic [7:0] idx;
    logic [7:0] body_len;
    logic [15:0] resp_word;
    logic [7:0] tx_data;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic ext_req;
    logic [7:0] ext_func;
    logic [7:0] ext_sub;
    logic [`NUM_COUNTERS-1:0] inc;
    logic clr;
  } dec_s;

  dec_s q_reg;
  dec_s q_next;

  crc_link rx_lk ();
  crc_link tx_lk ();
  diag_link dg_lk ();

  // ----------------------------------------------------------------
  // field decoding
  // ----------------------------------------------------------------
  function automatic logic [15:0] word_at(input dec_s s, input logic [2:0] p);
    word_at = {s.req[p], s.req[p + 3'h1]};
  endfunction

  function automatic logic [7:0] body_byte(input dec_s s, input logic [7:0] i);
    logic [7:0] j;
    logic [15:0] w;
    j = i - `READ_HDR_LEN;
    w = s.words[j[7:1]];
    body_byte = s.req[i[2:0]];
    if (s.kind == resp_exc) begin
      if (i[2:0] == `POS_OP) begin
        body_byte = s.req[`POS_OP] | `OPC_ERR_BIT;
      end else if (i[2:0] == `POS_F0) begin
        body_byte = s.exc;
      end
    end else if (s.kind == resp_read) begin
      if (i == {5'h00, `POS_F0}) begin
        body_byte = s.body_len - `READ_HDR_LEN;
      end else if (i > {5'h00, `POS_F0}) begin
        body_byte = j[0] ? w[7:0] : w[15:8];
      end
    end else begin
      if (i[2:0] == `POS_F2) begin
        body_byte = s.resp_word[15:8];
      end else if (i[2:0] == `POS_F3) begin
        body_byte = s.resp_word[7:0];
      end
    end
  endfunction

  logic [7:0] op;
  logic [15:0] w_first;
  logic [15:0] w_second;
  logic bcast;
  logic mine;
  logic fixed_len;
  logic in_pdo;
  assign op = q_reg.req[`POS_OP];
  assign w_first = word_at(q_reg, `POS_F0);
  assign w_second = word_at(q_reg, `POS_F2);
  assign bcast = q_reg.req[`POS_STATION] == `BCAST_ADDR;
  assign mine = q_reg.req[`POS_STATION] == station_addr;
  assign fixed_len = q_reg.rx_cnt == `REQ_FIXED_LEN;
  assign in_pdo = (w_first >= PDO_LO) && (w_first <= PDO_HI);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    logic to_body;
    to_body = 1'b0;
    q_next = q_reg;
    q_next.ext_req = 1'b0;
    q_next.clr = 1'b0;
    q_next.inc = '0;
    q_next.inc[`CNT_OVERRUN] = rx_overrun;
    unique case (q_reg.st)
      st_idle: begin
        if (rx_valid) begin
          if (q_reg.rx_cnt < `REQ_FIXED_LEN) begin
            q_next.req[q_reg.rx_cnt[2:0]] = rx_data;
          end
          if (q_reg.rx_cnt != `RX_CNT_MAX) begin
            q_next.rx_cnt = q_reg.rx_cnt + 8'h01;
          end
        end
        if (rx_end) begin
          q_next.st = st_check;
        end
      end
      st_check: begin
        q_next.st = st_idle;
        q_next.rx_cnt = 8'h00;
        q_next.idx = 8'h00;
        if (q_reg.rx_cnt >= `FRAME_MIN_LEN) begin
          if (rx_lk.crc != `CRC_GOOD) begin
            q_next.inc[`CNT_BUS_ERR] = 1'b1;
          end else begin
            q_next.inc[`CNT_BUS_MSG] = 1'b1;
            if (bcast || mine) begin
              q_next.inc[`CNT_SRV_MSG] = 1'b1;
              q_next.kind = resp_exc;
              q_next.exc = `EXC_ILL_FUNC;
              to_body = 1'b1;
              case (op)
                `OPC_RD_HOLD, `OPC_RD_INPUT: begin
                  if (!fixed_len || w_second == 16'h0000 || w_second > 16'(MAX_REGS)) begin
                    q_next.exc = `EXC_ILL_VALUE;
                  end else if (in_pdo && w_first[0]) begin
                    q_next.exc = `EXC_ILL_ADDR;
                  end else begin
                    to_body = 1'b0;
                    q_next.st = st_read;
                    q_next.addr = w_first;
                    q_next.we = 1'b0;
                  end
                end
                `OPC_WR_SINGLE: begin
                  if (!fixed_len) begin
                    q_next.exc = `EXC_ILL_VALUE;
                  end else begin
                    to_body = 1'b0;
                    q_next.st = st_write;
                    q_next.addr = w_first;
                    q_next.wdata = w_second;
                    q_next.we = 1'b1;
                  end
                end
                `OPC_DIAG: begin
                  if (!fixed_len || q_reg.req[`POS_F0] != `SUB_HI_ZERO) begin
                    q_next.exc = `EXC_ILL_VALUE;
                  end else if (q_reg.req[`POS_F1] == `SUB_CLEAR) begin
                    q_next.clr = 1'b1;
                    q_next.kind = resp_echo;
                    q_next.resp_word = w_second;
                  end else if (q_reg.req[`POS_F1] >= `SUB_FIRST_CNT && q_reg.req[`POS_F1] <= `SUB_LAST_CNT) begin
                    q_next.kind = resp_echo;
                    q_next.resp_word = dg_lk.value;
                  end
                end
                `OPC_WR_MULTI, `OPC_RDWR_MULTI: begin
                  to_body = 1'b0;
                  q_next.ext_req = 1'b1;
                  q_next.ext_sub = `SUB_HI_ZERO;
                end
                `OPC_ENCAP: begin
                  if (q_reg.req[`POS_F0] == `MEI_CAN) begin
                    to_body = 1'b0;
                    q_next.ext_req = 1'b1;
                    q_next.ext_sub = `MEI_CAN;
                  end
                end
                `OPC_DICT_ALL, `OPC_DICT_OBJ: begin
                  if (q_reg.req[`POS_F0] == `SUB_START || q_reg.req[`POS_F0] == `SUB_NEXT) begin
                    to_body = 1'b0;
                    q_next.ext_req = 1'b1;
                    q_next.ext_sub = q_reg.req[`POS_F0];
                  end
                end
                default: begin
                  to_body = 1'b1;
                end
              endcase
              q_next.ext_func = op;
              if (q_next.ext_req && bcast) begin
                q_next.inc[`CNT_SRV_NO_RESP] = 1'b1;
              end
            end
          end
        end
      end
      st_read: begin
        if (reg_ack) begin
          if (reg_exc != `EXC_NONE) begin
            q_next.kind = resp_exc;
            q_next.exc = reg_exc;
            to_body = 1'b1;
          end else begin
            q_next.words[q_reg.idx] = reg_rdata;
            q_next.idx = q_reg.idx + 8'h01;
            q_next.addr = q_reg.addr + 16'h0001;
            if (q_next.idx == w_second[7:0]) begin
              q_next.kind = resp_read;
              to_body = 1'b1;
            end
          end
        end
      end
      st_write: begin
        if (reg_ack) begin
          q_next.kind = (reg_exc != `EXC_NONE) ? resp_exc : resp_echo;
          q_next.exc = reg_exc;
          q_next.resp_word = q_reg.wdata;
          to_body = 1'b1;
        end
      end
      st_body: begin
        if (tx_ready) begin
          q_next.idx = q_reg.idx + 8'h01;
          if (q_next.idx == q_reg.body_len) begin
            q_next.st = st_crc_load;
          end else begin
            q_next.tx_data = body_byte(q_reg, q_next.idx);
          end
        end
      end
      st_crc_load: begin
        q_next.tx_data = tx_lk.crc[7:0];
        q_next.st = st_crc_lo;
      end
      st_crc_lo: begin
        if (tx_ready) begin
          q_next.tx_data = tx_lk.crc[15:8];
          q_next.st = st_crc_hi;
        end
      end
      st_crc_hi: begin
        if (tx_ready) begin
          q_next.st = st_idle;
        end
      end
    endcase
    // common entry to the answer; broadcasts stay silent
    if (to_body) begin
      q_next.idx = 8'h00;
      q_next.tx_data = q_reg.req[`POS_STATION];
      unique case (q_next.kind)
        resp_exc: q_next.body_len = `EXC_BODY_LEN;
        resp_read: q_next.body_len = `READ_HDR_LEN + {w_second[6:0], 1'b0};
        resp_echo: q_next.body_len = `ECHO_BODY_LEN;
      endcase
      if (bcast) begin
        q_next.st = st_idle;
        q_next.inc[`CNT_SRV_NO_RESP] = 1'b1;
      end else begin
        q_next.st = st_body;
        q_next.inc[`CNT_BUS_EXC] = q_next.kind == resp_exc;
      end
    end
  end

  // reset image: idle, empty request, exception kind
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // crc and counter units
  // ----------------------------------------------------------------
  assign rx_lk.clr = q_reg.st == st_check;
  assign rx_lk.en = (q_reg.st == st_idle) && rx_valid;
  assign rx_lk.data = rx_data;
  assign tx_lk.clr = q_reg.st == st_check;
  assign tx_lk.en = (q_reg.st == st_body) && tx_ready;
  assign tx_lk.data = q_reg.tx_data;
  assign dg_lk.inc = q_reg.inc;
  assign dg_lk.clr = q_reg.clr;
  assign dg_lk.sel = 3'(q_reg.req[`POS_F1] - `SUB_FIRST_CNT);

  crc16_engine u_rx_crc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lk(rx_lk.engine)
  );

  crc16_engine u_tx_crc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lk(tx_lk.engine)
  );

  diag_counters #(
    .WIDTH(16)
  ) u_diag (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lk(dg_lk.engine)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_valid = (q_reg.st == st_body) || (q_reg.st == st_crc_lo) || (q_reg.st == st_crc_hi);
  assign tx_data = q_reg.tx_data;
  assign tx_last = q_reg.st == st_crc_hi;
  assign reg_req = (q_reg.st == st_read) || (q_reg.st == st_write);
  assign reg_we = q_reg.we;
  assign reg_addr = q_reg.addr;
  assign reg_wdata = q_reg.wdata;
  assign ext_req = q_reg.ext_req;
  assign ext_func = q_reg.ext_func;
  assign ext_sub = q_reg.ext_sub;
  assign diag_status = dg_lk.flags;
endmodule // modbus_rtu_slave_function_decoder
`default_nettype wire

// [testbench/modbus_decoder_chk.sv]
// concurrent checks on the slave decoder ports
`default_nettype none
`include "modbus_consts.svh"
module modbus_decoder_chk #(
  parameter int MAX_REGS = 125,
  parameter logic [15:0] PDO_LO = 16'h0000,
  parameter logic [15:0] PDO_HI = 16'h0FFF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // receive side
  input wire logic [7:0] station_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_overrun,
  // transmit side
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  // storage
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0] reg_exc,
  // hand-off and status
  input wire logic ext_req,
  input wire logic [7:0] ext_func,
  input wire logic [7:0] ext_sub,
  input wire logic [`NUM_COUNTERS-1:0] diag_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------
  // words fetched in the current read burst
  // ---------------------------------------------
  logic [7:0] nrd;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) nrd <= 8'h00;
    else if (!reg_req) nrd <= 8'h00;
    else if (reg_ack && !reg_we) nrd <= nrd + 8'h01;
  end
  a_last_with_valid: assert property (tx_last |-> tx_valid) else $error("tx_last without tx_valid");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed before taken");
  a_frame_end: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid) else $error("bytes after last");
  a_req_hold: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_addr) && $stable(reg_we))
    else $error("storage request dropped early");
  a_read_step: assert property ((reg_req && reg_ack && !reg_we) ##1 reg_req |-> reg_addr == $past(reg_addr) + 16'h0001)
    else $error("read address did not step");
  a_burst_limit: assert property (nrd <= MAX_REGS) else $error("read burst too long");
  a_pdo_even: assert property ($rose(reg_req) && !reg_we && reg_addr >= PDO_LO && reg_addr <= PDO_HI |-> !reg_addr[0])
    else $error("unaligned process data read");
  a_ext_pulse: assert property (ext_req |=> !ext_req) else $error("hand-off longer than a pulse");
  a_ext_code: assert property (ext_req |-> ext_func inside {8'h10, 8'h17, 8'h2B, 8'h65, 8'h66} && !tx_valid)
    else $error("bad hand-off function");
  a_ext_sub: assert property (ext_req && ext_func inside {8'h65, 8'h66} |-> ext_sub inside {8'h55, 8'hAA})
    else $error("bad dictionary subcode");
endmodule // modbus_decoder_chk
bind modbus_rtu_slave_function_decoder modbus_decoder_chk #(.MAX_REGS(MAX_REGS), .PDO_LO(PDO_LO), .PDO_HI(PDO_HI))
  u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .station_addr(station_addr), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_end(rx_end), .rx_overrun(rx_overrun), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .tx_last(tx_last), .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_exc(reg_exc), .ext_req(ext_req),
  .ext_func(ext_func), .ext_sub(ext_sub), .diag_status(diag_status));
`default_nettype wire

// [testbench/rtu_master_model.sv]
// bus master model: frames requests, collects replies
`default_nettype none
module rtu_master_model (
  // clock
  input wire logic ref_clk,
  // request bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  // reply bytes
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] resp[$];
  logic slow = 1'b0;
  logic done = 1'b0;
  logic ph = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // slow mode drops tx_ready on every other cycle
  always @(posedge ref_clk) begin
    ph <= ~ph;
    tx_ready <= ~slow | ph;
    if (tx_valid && tx_ready) resp.push_back(tx_data);
    if (tx_valid && tx_ready && tx_last) done <= 1'b1;
  end
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    resp.delete();
    done = 1'b0;
    foreach (q[i]) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_end <= (i == q.size() - 1);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_end <= 1'b0;
    // a released line must not keep showing the last byte
    rx_data <= ~q[q.size() - 1];
  endtask
endmodule // rtu_master_model
`default_nettype wire

// [testbench/modbus_rtu_slave_function_decoder_test.sv]
// self-checking bench of the slave decoder
`default_nettype none
module modbus_rtu_slave_function_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import modbus_pkg::*;
  localparam logic [47:0] EXC_T [9] = '{48'h410000000101, 48'h032000000003, 48'h032000007E03,
    48'h040001000202, 48'h080013000001, 48'h08010B000003, 48'h2B0E00000001, 48'h660000000001, 48'h65BB00000001};
  logic ref_clk, sys_rst, rx_valid, rx_end, rx_overrun, tx_valid, tx_ready, tx_last;
  logic reg_req, reg_we, ext_req;
  logic reg_ack = 1'b0;
  logic [7:0] station_addr, rx_data, tx_data, ext_func, ext_sub, diag_status, exc_cfg;
  logic [7:0] reg_exc = 8'h00;
  logic [15:0] reg_addr, reg_wdata, wa, wd;
  logic [15:0] reg_rdata = 16'h0000;
  logic [1:0] wcnt = 2'h0;
  int error_cnt = 0;
  int checks_done = 0;
  modbus_rtu_slave_function_decoder u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .station_addr(station_addr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_overrun(rx_overrun), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_exc(reg_exc),
    .ext_req(ext_req), .ext_func(ext_func), .ext_sub(ext_sub), .diag_status(diag_status));
  rtu_master_model u_master (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  // ---------------------------------------------
  // storage: answers after three wait cycles
  // ---------------------------------------------
  always @(posedge ref_clk) begin
    reg_ack <= 1'b0;
    reg_rdata <= ~reg_rdata;
    if (reg_req && !reg_ack) wcnt <= wcnt + 2'h1;
    if (reg_req && !reg_ack && wcnt == 2'h2) begin
      reg_ack <= 1'b1;
      wcnt <= 2'h0;
      reg_rdata <= reg_addr ^ 16'hA5A5;
      reg_exc <= exc_cfg;
      if (reg_we) wa <= reg_addr;
      if (reg_we) wd <= reg_wdata;
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$]);
    logic [15:0] c;
    c = u_master.crc16(e);
    u_master.send(q, 1'b0);
    if (e.size() == 0) begin
      repeat (40) @(posedge ref_clk);
      chk("silence", 16'h0000, 16'(u_master.resp.size()));
      return;
    end
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    for (int n = 0; n < 3000 && u_master.done !== 1'b1; n++) @(posedge ref_clk);
    chk("length", 16'(e.size()), 16'(u_master.resp.size()));
    foreach (e[i]) chk("tx byte", {8'h00, e[i]}, {8'h00, u_master.resp[i]});
    // one slave on this bus, so a short turnaround is enough
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] fn, input logic [15:0] a, input logic [7:0] n);
    logic [7:0] e[$];
    logic [15:0] v;
    e = '{8'h05, fn, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      v = (a + 16'(i)) ^ 16'hA5A5;
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    xfer('{8'h05, fn, a[15:8], a[7:0], 8'h00, n}, e);
  endtask
  task automatic t_read();
    u_master.slow = 1'b1;
    rd(8'h03, 16'h1388, 8'h02);
    rd(8'h04, 16'h2000, 8'h7D);
    rd(8'h03, 16'h0002, 8'h02);
    u_master.slow = 1'b0;
  endtask
  task automatic t_write();
    exc_cfg = 8'h00;
    xfer('{8'h05, 8'h06, 8'h17, 8'h70, 8'h00, 8'h01}, '{8'h05, 8'h06, 8'h17, 8'h70, 8'h00, 8'h01});
    chk("write addr", 16'h1770, wa);
    chk("write data", 16'h0001, wd);
    exc_cfg = 8'h04;
    xfer('{8'h05, 8'h06, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, '{8'h05, 8'h86, 8'h04});
    exc_cfg = 8'h00;
  endtask
  task automatic t_exc();
    foreach (EXC_T[i]) xfer('{8'h05, EXC_T[i][47:40], EXC_T[i][39:32], EXC_T[i][31:24], EXC_T[i][23:16],
      EXC_T[i][15:8]}, '{8'h05, EXC_T[i][47:40] | 8'h80, EXC_T[i][7:0]});
  endtask
  task automatic t_diag();
    logic [15:0] ex [8] = '{16'h0001, 16'h0001, 16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
    xfer('{8'h05, 8'h08, 8'h00, 8'h0A, 8'h12, 8'h34}, '{8'h05, 8'h08, 8'h00, 8'h0A, 8'h12, 8'h34});
    chk("diag status", 16'h0000, {8'h00, diag_status});
    u_master.send('{8'h05, 8'h08, 8'h00, 8'h0B, 8'h00, 8'h00}, 1'b1);
    repeat (40) @(posedge ref_clk);
    chk("bad crc dropped", 16'h0000, 16'(u_master.resp.size()));
    @(posedge ref_clk) rx_overrun <= 1'b1;
    @(posedge ref_clk) rx_overrun <= 1'b0;
    for (int i = 0; i < 8; i++) xfer('{8'h05, 8'h08, 8'h00, 8'(11 + i), 8'h00, 8'h00},
      '{8'h05, 8'h08, 8'h00, 8'(11 + i), ex[i][15:8], ex[i][7:0]});
  endtask
  task automatic t_bcast();
    xfer('{8'h00, 8'h06, 8'h00, 8'h10, 8'hBE, 8'hEF}, '{});
    chk("broadcast addr", 16'h0010, wa);
    chk("broadcast data", 16'hBEEF, wd);
    xfer('{8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00}, '{});
  endtask
  task automatic t_ext();
    logic [15:0] t [7] = '{16'h1000, 16'h1700, 16'h2B0D, 16'h6555, 16'h65AA, 16'h6655, 16'h66AA};
    int hits;
    foreach (t[i]) begin
      hits = 0;
      fork
        xfer('{8'h05, t[i][15:8], t[i][7:0], 8'h00, 8'h00, 8'h00}, '{});
        repeat (30) @(posedge ref_clk)
          if (ext_req === 1'b1 && ext_func === t[i][15:8] && ext_sub === t[i][7:0]) hits++;
      join
      chk("hand-off", 16'h0001, 16'(hits));
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // watchdog well beyond the few thousand cycles the scenarios need
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1;
    station_addr = 8'h05;
    rx_overrun = 1'b0;
    exc_cfg = 8'h00;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_read();
    t_write();
    t_exc();
    t_diag();
    t_bcast();
    t_ext();
    complete_run();
  end
endmodule // modbus_rtu_slave_function_decoder_test
`default_nettype wire
